// [pkg/epi_params.svh]
/*
  Constants of the execution pipeline interlock: stage numbers, location
  identifiers used by the hazard scoreboard and datapath widths.
  Assumes it is included by the package, the hazard detector and the pipeline.
*/
`ifndef EPI_PARAMS_SVH
`define EPI_PARAMS_SVH

// Stage positions, D is the decode slot ahead of the pipe
`define EPI_STG_D    3'd0
`define EPI_STG_AD   3'd1
`define EPI_STG_AC1  3'd2
`define EPI_STG_AC2  3'd3
`define EPI_STG_R    3'd4
`define EPI_STG_X    3'd5
`define EPI_STG_W    3'd6
`define EPI_STG_WP   3'd7
`define EPI_LAST     7

// Tracked locations
`define EPI_NLOC     17
`define EPI_LOC_ACC0 5'd8
`define EPI_LOC_SP   5'd12
`define EPI_LOC_SSP  5'd13
`define EPI_LOC_CPL  5'd14
`define EPI_LOC_MEM  5'd15
`define EPI_LOC_IO   5'd16

// Widths and counts
`define EPI_XPTR_W   23
`define EPI_PTR_LO_W 16
`define EPI_ACC_W    40
`define EPI_DATA_W   16
`define EPI_NPTR     8
`define EPI_NACC     4

`endif

// [pkg/epi_pkg.sv]
/*
  Types and location decoding of the execution pipeline interlock.
  Assumes instructions arrive already decoded into epi_instr_t.
*/
package epi_pkg;
  `include "epi_params.svh"

  typedef enum logic [4:0] {
    EPI_NOP, EPI_XPTR_IMM, EPI_PTR_IMM, EPI_PTR_IMM_MMR, EPI_PTR_ADD_EARLY,
    EPI_ST_IMM_INC, EPI_LD_ACC_INC, EPI_PTR_ADD, EPI_ACC_ADD, EPI_ACC_PTR_MMR,
    EPI_ACC_PTR, EPI_SET_CPL, EPI_PUSH, EPI_POP, EPI_RET, EPI_SP_ADD,
    EPI_ST_ACC_INC, EPI_IO_WR
  } epi_op_t;

  typedef enum logic [1:0] {EPI_CND_NONE, EPI_CND_PART, EPI_CND_WHOLE} epi_cond_t;

  typedef logic [`EPI_NLOC-1:0] epi_loc_t;

  typedef struct packed {
    logic                   vld;
    epi_op_t                op;
    epi_cond_t              cond;
    logic                   par;
    logic [2:0]             ptr;
    logic [1:0]             acc;
    logic [1:0]             src;
    logic [1:0]             cacc;
    logic [`EPI_XPTR_W-1:0] imm;
  } epi_instr_t;

  typedef struct packed {
    epi_instr_t             ins;
    logic                   ok;
    logic [`EPI_XPTR_W-1:0] addr;
    logic [`EPI_ACC_W-1:0]  val;
  } epi_slot_t;

  typedef struct packed {
    logic                   vld;
    logic [`EPI_XPTR_W-1:0] addr;
    logic [`EPI_DATA_W-1:0] data;
  } epi_bus_t;

  typedef struct packed {
    logic                  vld;
    logic [1:0]            idx;
    logic [`EPI_ACC_W-1:0] val;
  } epi_upd_t;

  function automatic logic epi_wr_mem(epi_op_t op);
    return op == EPI_ST_IMM_INC || op == EPI_ST_ACC_INC || op == EPI_PUSH;
  endfunction

  function automatic logic epi_stack(epi_op_t op);
    return op == EPI_PUSH || op == EPI_POP || op == EPI_RET || op == EPI_SP_ADD;
  endfunction

  function automatic logic epi_post_inc(epi_op_t op);
    return op == EPI_ST_IMM_INC || op == EPI_LD_ACC_INC || op == EPI_ST_ACC_INC;
  endfunction

  function automatic logic epi_ovf(logic [`EPI_ACC_W-1:0] a);
    return !((&a[39:31]) || !(|a[39:31]));
  endfunction

  // Locations an instruction reads while it sits in stage s
  function automatic epi_loc_t epi_rd_mask(epi_instr_t i, logic [2:0] s);
    epi_loc_t m;
    epi_loc_t pm;
    epi_loc_t am;
    m  = '0;
    pm = epi_loc_t'(1) << i.ptr;
    am = epi_loc_t'(1) << (`EPI_LOC_ACC0 + 5'(i.acc));
    if ((epi_post_inc(i.op) || i.op == EPI_PTR_ADD_EARLY) && s == `EPI_STG_AD) m |= pm;
    if ((i.op == EPI_PTR_ADD || i.op == EPI_ACC_PTR) && s == `EPI_STG_X) m |= pm;
    if (i.op == EPI_ACC_PTR_MMR && s == `EPI_STG_R) m |= pm;
    if (i.op == EPI_ACC_ADD && s == `EPI_STG_X) begin
      m |= am | (epi_loc_t'(1) << (`EPI_LOC_ACC0 + 5'(i.src)));
    end
    if ((i.op == EPI_LD_ACC_INC || i.op == EPI_POP) && s == `EPI_STG_R) begin
      m[`EPI_LOC_MEM] = 1'b1;
    end
    if (epi_stack(i.op) && s == `EPI_STG_AD) begin
      m[`EPI_LOC_SP]  = 1'b1;
      m[`EPI_LOC_SSP] = 1'b1;
    end
    if ((i.op == EPI_PUSH || i.op == EPI_ST_ACC_INC || i.op == EPI_IO_WR) && s == `EPI_STG_X) begin
      m |= am;
    end
    if ((i.cond == EPI_CND_WHOLE && s == `EPI_STG_AD) ||
        (i.cond == EPI_CND_PART && s == (epi_wr_mem(i.op) ? `EPI_STG_R : `EPI_STG_X))) begin
      m |= epi_loc_t'(1) << (`EPI_LOC_ACC0 + 5'(i.cacc));
    end
    return m;
  endfunction

  // Locations an instruction writes at the end of stage s
  function automatic epi_loc_t epi_wr_mask(epi_instr_t i, logic [2:0] s);
    epi_loc_t m;
    epi_loc_t pm;
    m  = '0;
    pm = epi_loc_t'(1) << i.ptr;
    if (s == `EPI_STG_AD && (i.op == EPI_XPTR_IMM || i.op == EPI_PTR_ADD_EARLY ||
        epi_post_inc(i.op))) m |= pm;
    if (s == `EPI_STG_X && (i.op == EPI_PTR_IMM || i.op == EPI_PTR_ADD)) m |= pm;
    if (s == `EPI_STG_W && i.op == EPI_PTR_IMM_MMR) m |= pm;
    if (s == `EPI_STG_X && (i.op == EPI_LD_ACC_INC || i.op == EPI_ACC_ADD || i.op == EPI_POP ||
        i.op == EPI_ACC_PTR_MMR || i.op == EPI_ACC_PTR)) begin
      m |= epi_loc_t'(1) << (`EPI_LOC_ACC0 + 5'(i.acc));
    end
    if (s == `EPI_STG_X && i.op == EPI_SET_CPL) m[`EPI_LOC_CPL] = 1'b1;
    if (s == `EPI_STG_AD && epi_stack(i.op)) begin
      m[`EPI_LOC_SP]  = 1'b1;
      m[`EPI_LOC_SSP] = 1'b1;
    end
    if (s == `EPI_STG_W && epi_wr_mem(i.op)) m[`EPI_LOC_MEM] = 1'b1;
    if (s == `EPI_STG_W && i.op == EPI_IO_WR) m[`EPI_LOC_IO] = 1'b1;
    return m;
  endfunction
endpackage

// [verilog/epi_hazard.sv]
/*
  Hazard detector: decides whether the instruction that will sit in the
  decode slot must be held back from the address stage.
  Assumes it sees next-cycle contents of the decode slot and of the pipe.
*/
`timescale 1ns/10ps
`include "epi_params.svh"
module epi_hazard import epi_pkg::*; (
  // Candidate in decode
  input  wire epi_instr_t nxt,
  // Older instructions, index is the stage they will occupy
  input  wire epi_instr_t pipe [1:`EPI_LAST],
  // Verdict
  output      logic       hold
);

  always_comb begin
    hold = 1'b0;
    for (int p = 1; p <= `EPI_LAST; p++) begin
      // The partner of a parallel pair is not guarded against the instruction just ahead of it
      if (nxt.vld && pipe[p].vld && !(p == 1 && nxt.par)) begin
        for (int s = 1; s <= `EPI_LAST; s++) begin
          for (int t = p; t <= `EPI_LAST; t++) begin
            if ((t - p >= s) &&
                (|(epi_rd_mask(nxt, 3'(s)) & epi_wr_mask(pipe[p], 3'(t))))) begin
              hold = 1'b1;
            end
            if ((t - p > s) &&
                (|(epi_wr_mask(nxt, 3'(s)) & epi_rd_mask(pipe[p], 3'(t))))) begin
              hold = 1'b1;
            end
            if ((t - p >= s) &&
                (|(epi_wr_mask(nxt, 3'(s)) & epi_wr_mask(pipe[p], 3'(t))))) begin
              hold = 1'b1;
            end
          end
        end
      end
    end
  end

endmodule // epi_hazard

// [verilog/epi_interlock.sv]
/*
  Execution pipeline with automatic interlock: eight stages from decode to
  memory commit, pointer, accumulator and stack state, and bubble insertion
  on read/write ordering conflicts.
  Assumes one decoded instruction offered per cycle on ins_in, taken when
  issue_ready_q is high, and memory read data one cycle after mem_rd_q.
*/
`timescale 1ns/10ps
`include "epi_params.svh"
module epi_interlock import epi_pkg::*; (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // Instruction issue
  input  wire epi_instr_t              ins_in,
  output      logic                    issue_ready_q,
  output      logic                    bubble_q,
  // Stack mode
  input  wire logic                    stack32,
  // Data memory
  output      epi_bus_t                mem_rd_q,
  input  wire logic [`EPI_DATA_W-1:0]  mem_rdata,
  output      epi_bus_t                mem_wr_q,
  // I/O space
  output      epi_bus_t                io_wr_q,
  // Architectural state
  output      logic                    cpl_q,
  output      logic [`EPI_PTR_LO_W-1:0] sp_q,
  output      logic [`EPI_PTR_LO_W-1:0] ssp_q,
  output      epi_upd_t                acc_wr_q
);

  epi_instr_t              d_q;
  epi_instr_t              d_d;
  epi_slot_t               pipe_q [1:`EPI_LAST];
  epi_slot_t               pipe_d [1:`EPI_LAST];
  epi_instr_t              pipe_ins [1:`EPI_LAST];
  logic [`EPI_XPTR_W-1:0]  ptr_q [`EPI_NPTR];
  logic [`EPI_XPTR_W-1:0]  ptr_d [`EPI_NPTR];
  logic [`EPI_ACC_W-1:0]   acc_q [`EPI_NACC];
  logic [`EPI_ACC_W-1:0]   acc_d [`EPI_NACC];
  logic [`EPI_PTR_LO_W-1:0] sp_d;
  logic [`EPI_PTR_LO_W-1:0] ssp_d;
  logic                    cpl_d;
  epi_bus_t                mem_rd_d;
  epi_bus_t                mem_wr_d;
  epi_bus_t                io_wr_d;
  epi_upd_t                acc_wr_d;
  epi_slot_t               ad_s;
  epi_slot_t               r_s;
  epi_slot_t               x_s;
  epi_slot_t               issue_s;
  logic                    hold;
  logic                    take;

  // Issue handshake and decode slot
  assign take = ins_in.vld && issue_ready_q;
  assign d_d  = issue_ready_q ? (take ? ins_in : '0) : d_q;

  // Decode slot entering the address stage; a held slot leaves a bubble
  assign issue_s = '{ins: (issue_ready_q ? d_q : '0), ok: 1'b1, addr: '0, val: '0};

  // Next-cycle view of the pipe for the hazard check
  assign pipe_ins[1] = pipe_d[1].ins;
  assign pipe_ins[2] = pipe_d[2].ins;
  assign pipe_ins[3] = pipe_d[3].ins;
  assign pipe_ins[4] = pipe_d[4].ins;
  assign pipe_ins[5] = pipe_d[5].ins;
  assign pipe_ins[6] = pipe_d[6].ins;
  assign pipe_ins[7] = pipe_d[7].ins;

  epi_hazard u_hazard (
    .nxt  (d_d),
    .pipe (pipe_ins),
    .hold (hold)
  );

  // Address stage
  always_comb begin
    ad_s  = pipe_q[1];
    ptr_d = ptr_q;
    sp_d  = sp_q;
    ssp_d = ssp_q;
    if (ad_s.ins.vld) begin
      if (ad_s.ins.cond == EPI_CND_WHOLE) begin
        ad_s.ok = epi_ovf(acc_q[ad_s.ins.cacc]);
      end
      if (ad_s.ok) begin
        unique case (ad_s.ins.op)
          EPI_XPTR_IMM: begin
            ptr_d[ad_s.ins.ptr] = ad_s.ins.imm;
          end
          EPI_PTR_ADD_EARLY: begin
            ptr_d[ad_s.ins.ptr] = ptr_q[ad_s.ins.ptr] + ad_s.ins.imm;
          end
          EPI_ST_IMM_INC, EPI_LD_ACC_INC, EPI_ST_ACC_INC: begin
            ad_s.addr           = ptr_q[ad_s.ins.ptr];
            ptr_d[ad_s.ins.ptr] = ptr_q[ad_s.ins.ptr] + 23'h000001;
          end
          EPI_PUSH: begin
            sp_d      = sp_q - 16'h0001;
            ad_s.addr = {7'h00, sp_q - 16'h0001};
            if (stack32) begin
              ssp_d = ssp_q - 16'h0001;
            end
          end
          EPI_POP, EPI_RET: begin
            sp_d      = sp_q + 16'h0001;
            ad_s.addr = {7'h00, sp_q};
            if (stack32) begin
              ssp_d = ssp_q + 16'h0001;
            end
          end
          EPI_SP_ADD: begin
            sp_d = sp_q + {{8{ad_s.ins.imm[7]}}, ad_s.ins.imm[7:0]};
            if (stack32) begin
              ssp_d = ssp_q + {{8{ad_s.ins.imm[7]}}, ad_s.ins.imm[7:0]};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Access stage: memory read request
  always_comb begin
    mem_rd_d = '0;
    if (pipe_q[2].ins.vld && pipe_q[2].ok &&
        (pipe_q[2].ins.op == EPI_LD_ACC_INC || pipe_q[2].ins.op == EPI_POP)) begin
      mem_rd_d = '{vld: 1'b1, addr: pipe_q[2].addr, data: '0};
    end
  end

  // Operand read stage
  always_comb begin
    r_s = pipe_q[4];
    if (r_s.ins.vld && r_s.ins.cond == EPI_CND_PART && epi_wr_mem(r_s.ins.op)) begin
      r_s.ok = epi_ovf(acc_q[r_s.ins.cacc]);
    end
    if (r_s.ins.vld && r_s.ok) begin
      if (r_s.ins.op == EPI_LD_ACC_INC || r_s.ins.op == EPI_POP) begin
        r_s.val = {{24{mem_rdata[15]}}, mem_rdata};
      end
      if (r_s.ins.op == EPI_ACC_PTR_MMR) begin
        r_s.val = {17'h00000, ptr_q[r_s.ins.ptr]};
      end
    end
  end

  // Compute stage
  always_comb begin
    x_s      = pipe_q[5];
    acc_d    = acc_q;
    cpl_d    = cpl_q;
    acc_wr_d = '0;
    if (x_s.ins.vld && x_s.ins.cond == EPI_CND_PART && !epi_wr_mem(x_s.ins.op)) begin
      x_s.ok = epi_ovf(acc_q[x_s.ins.cacc]);
    end
    if (x_s.ins.vld && x_s.ok) begin
      unique case (x_s.ins.op)
        EPI_LD_ACC_INC, EPI_POP, EPI_ACC_PTR_MMR: begin
          acc_wr_d = '{vld: 1'b1, idx: x_s.ins.acc, val: x_s.val};
        end
        EPI_ACC_ADD: begin
          acc_wr_d = '{vld: 1'b1, idx: x_s.ins.acc,
                       val: acc_q[x_s.ins.acc] + acc_q[x_s.ins.src]};
        end
        EPI_ACC_PTR: begin
          acc_wr_d = '{vld: 1'b1, idx: x_s.ins.acc,
                       val: {17'h00000, ptr_q[x_s.ins.ptr]}};
        end
        EPI_SET_CPL: begin
          cpl_d = 1'b1;
        end
        EPI_PUSH, EPI_ST_ACC_INC, EPI_IO_WR: begin
          x_s.val = acc_q[x_s.ins.acc];
        end
        default: begin
        end
      endcase
    end
    if (acc_wr_d.vld) begin
      acc_d[acc_wr_d.idx] = acc_wr_d.val;
    end
  end

  // Register-write and commit stages, and compute-stage pointer updates
  always_comb begin
    pipe_d[1] = issue_s;
    pipe_d[2] = ad_s;
    pipe_d[3] = pipe_q[2];
    pipe_d[4] = pipe_q[3];
    pipe_d[5] = r_s;
    pipe_d[6] = x_s;
    pipe_d[7] = pipe_q[6];
    io_wr_d   = '0;
    mem_wr_d  = '0;
    if (x_s.ins.vld && x_s.ok && x_s.ins.op == EPI_PTR_IMM) begin
      pipe_d[6].addr = {ptr_q[x_s.ins.ptr][22:16], x_s.ins.imm[15:0]};
    end
    if (x_s.ins.vld && x_s.ok && x_s.ins.op == EPI_PTR_ADD) begin
      pipe_d[6].addr = ptr_q[x_s.ins.ptr] + x_s.ins.imm;
    end
    if (pipe_q[6].ins.vld && pipe_q[6].ok && pipe_q[6].ins.op == EPI_IO_WR) begin
      io_wr_d = '{vld: 1'b1, addr: {7'h00, pipe_q[6].ins.imm[15:0]},
                  data: pipe_q[6].val[15:0]};
    end
    if (pipe_q[7].ins.vld && pipe_q[7].ok && epi_wr_mem(pipe_q[7].ins.op)) begin
      mem_wr_d = '{vld: 1'b1, addr: pipe_q[7].addr,
                   data: (pipe_q[7].ins.op == EPI_ST_IMM_INC) ? pipe_q[7].ins.imm[15:0]
                                                              : pipe_q[7].val[15:0]};
    end
  end

  // Pointer writes from compute and register-write stages on top of address stage
  function automatic logic [`EPI_XPTR_W-1:0] epi_ptr_next(
    logic [2:0] idx, logic [`EPI_XPTR_W-1:0] base);
    logic [`EPI_XPTR_W-1:0] v;
    v = base;
    if (x_s.ins.vld && x_s.ok && x_s.ins.ptr == idx &&
        (x_s.ins.op == EPI_PTR_IMM || x_s.ins.op == EPI_PTR_ADD)) begin
      v = pipe_d[6].addr;
    end
    if (pipe_q[6].ins.vld && pipe_q[6].ok && pipe_q[6].ins.ptr == idx &&
        pipe_q[6].ins.op == EPI_PTR_IMM_MMR) begin
      v = {ptr_q[idx][22:16], pipe_q[6].ins.imm[15:0]};
    end
    return v;
  endfunction

  // State and pipe registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      d_q           <= '0;
      issue_ready_q <= 1'b1;
      bubble_q      <= 1'b0;
      for (int p = 1; p <= `EPI_LAST; p++) begin
        pipe_q[p] <= '0;
      end
    end else begin
      d_q           <= d_d;
      issue_ready_q <= !(d_d.vld && hold);
      bubble_q      <= !issue_ready_q;
      for (int p = 1; p <= `EPI_LAST; p++) begin
        pipe_q[p] <= pipe_d[p];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < `EPI_NPTR; i++) begin
        ptr_q[i] <= '0;
      end
      for (int i = 0; i < `EPI_NACC; i++) begin
        acc_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `EPI_NPTR; i++) begin
        ptr_q[i] <= epi_ptr_next(3'(i), ptr_d[i]);
      end
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sp_q     <= '0;
      ssp_q    <= '0;
      cpl_q    <= 1'b0;
      mem_rd_q <= '0;
      mem_wr_q <= '0;
      io_wr_q  <= '0;
      acc_wr_q <= '0;
    end else begin
      sp_q     <= sp_d;
      ssp_q    <= ssp_d;
      cpl_q    <= cpl_d;
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      io_wr_q  <= io_wr_d;
      acc_wr_q <= acc_wr_d;
    end
  end

endmodule // epi_interlock

// [dv/epi_asserts.sv]
/*
  Port assertions of the interlocked execution pipeline.
  Assumes it is bound to epi_interlock; one clock, synchronous reset.
*/
`timescale 1ns/10ps
module epi_asserts import epi_pkg::*; (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Issue
  input wire epi_instr_t ins_in,
  input wire logic       issue_ready_q,
  input wire logic       bubble_q,
  input wire logic       stack32,
  // Results
  input wire epi_bus_t   mem_rd_q,
  input wire epi_bus_t   mem_wr_q,
  input wire epi_bus_t   io_wr_q,
  input wire logic       cpl_q,
  input wire logic [15:0] sp_q,
  input wire logic [15:0] ssp_q,
  input wire epi_upd_t   acc_wr_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Unconditional instruction taken at this edge
  wire take = ins_in.vld && issue_ready_q && ins_in.cond == EPI_CND_NONE;

  cpl_set_a: assert property (
    take && ins_in.op == EPI_SET_CPL ##1 issue_ready_q |-> ##6 cpl_q)
    else $error("compiler mode flag not set in compute stage");
  acc_x_write_a: assert property (
    take && ins_in.op inside {EPI_LD_ACC_INC, EPI_ACC_ADD, EPI_ACC_PTR, EPI_ACC_PTR_MMR}
    ##1 issue_ready_q |-> ##6 acc_wr_q.vld && acc_wr_q.idx == $past(ins_in.acc, 7))
    else $error("accumulator not written in compute stage");
  mem_rd_time_a: assert property (
    take && ins_in.op == EPI_LD_ACC_INC ##1 issue_ready_q |-> ##3 mem_rd_q.vld)
    else $error("memory read request missing");
  mem_wr_commit_a: assert property (
    take && ins_in.op == EPI_ST_IMM_INC ##1 issue_ready_q
    |-> ##8 mem_wr_q.vld && mem_wr_q.data == $past(ins_in.imm[15:0], 9))
    else $error("immediate store not committed one stage after write");
  io_wr_time_a: assert property (
    take && ins_in.op == EPI_IO_WR ##1 issue_ready_q
    |-> ##7 io_wr_q.vld && io_wr_q.addr[15:0] == $past(ins_in.imm[15:0], 8))
    else $error("io write not in write stage");
  sp_push_a: assert property (
    take && ins_in.op == EPI_PUSH ##1 issue_ready_q |-> ##2 sp_q == $past(sp_q) - 16'h1)
    else $error("push did not move stack pointer in address stage");
  ssp_mode_a: assert property (
    $changed(ssp_q) && !$past(reset) |-> stack32 && $past(stack32))
    else $error("system stack pointer moved outside 32-bit mode");
  bubble_quiet_a: assert property (
    bubble_q |-> ##2 !mem_rd_q.vld ##3 !acc_wr_q.vld ##1 !io_wr_q.vld ##1 !mem_wr_q.vld)
    else $error("protection bubble caused a side effect");
endmodule // epi_asserts

// [dv/test_execution_pipeline_interlock.sv]
/*
  Self-checking bench of epi_interlock: issues decoded instructions,
  answers memory reads and judges the visible effects.
  Assumes the package, design and checker are compiled before it.
*/
`timescale 1ns/10ps
module test_execution_pipeline_interlock import epi_pkg::*;;
  logic        clk_sys, reset, stack32, issue_ready_q, bubble_q, cpl_q;
  epi_instr_t  ins_in;
  logic [15:0] mem_rdata, sp_q, ssp_q;
  epi_bus_t    mem_rd_q, mem_wr_q, io_wr_q;
  epi_upd_t    acc_wr_q;
  int          errors, checked, nbub;
  logic [22:0] rdq[$];
  epi_bus_t    wrq[$], ioq[$];
  epi_upd_t    awq[$];

  epi_interlock dut (
    .clk_sys, .reset, .ins_in, .issue_ready_q, .bubble_q, .stack32, .mem_rd_q,
    .mem_rdata, .mem_wr_q, .io_wr_q, .cpl_q, .sp_q, .ssp_q, .acc_wr_q
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Memory answers one cycle after the request, a changing pattern otherwise
  always @(posedge clk_sys) begin
    mem_rdata <= (mem_rd_q.vld === 1'b1) ? mem_rd_q.addr[15:0] ^ 16'h8c00 : ~mem_rdata;
    if (bubble_q === 1'b1) nbub++;
    if (mem_rd_q.vld === 1'b1) rdq.push_back(mem_rd_q.addr);
    if (mem_wr_q.vld === 1'b1) wrq.push_back(mem_wr_q);
    if (io_wr_q.vld === 1'b1) ioq.push_back(io_wr_q);
    if (acc_wr_q.vld === 1'b1) awq.push_back(acc_wr_q);
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Offer one instruction and hold it until taken
  task automatic send(input epi_op_t o, input int p, input int a, input int k,
                      input epi_cond_t c = EPI_CND_NONE, input logic pp = 1'b0);
    int n;
    ins_in <= '{vld:1'b1, op:o, cond:c, par:pp, ptr:p[2:0], acc:a[1:0], src:2'd3,
                cacc:2'd0, imm:k[22:0]};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (issue_ready_q !== 1'b1 && n < 50);
  endtask

  task automatic idle(input int n);
    ins_in <= '0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic clr;
    rdq = {};
    wrq = {};
    ioq = {};
    awq = {};
  endtask

  task automatic t_ptr;
    logic [22:0] e [6] = '{23'h41234, 23'h41235, 23'h40200, 23'h40211, 23'h40215, 23'h40300};
    logic [15:0] d;
    clr;
    send(EPI_XPTR_IMM, 1, 0, 'h41234);
    send(EPI_LD_ACC_INC, 1, 1, 0);
    send(EPI_LD_ACC_INC, 1, 1, 0);
    send(EPI_PTR_IMM, 1, 0, 'h0200);
    send(EPI_LD_ACC_INC, 1, 1, 0);
    send(EPI_PTR_ADD_EARLY, 1, 0, 'h10);
    send(EPI_LD_ACC_INC, 1, 1, 0);
    send(EPI_PTR_ADD, 1, 0, 'h3);
    send(EPI_LD_ACC_INC, 1, 1, 0);
    send(EPI_PTR_IMM_MMR, 1, 0, 'h0300);
    send(EPI_LD_ACC_INC, 1, 1, 0);
    idle(20);
    chk(rdq.size(), 6, "read count");
    foreach (e[i]) begin
      d = e[i][15:0] ^ 16'h8c00;
      chk(rdq[i], e[i], "read address");
      chk(awq[i].val, {{24{d[15]}}, d}, "loaded accumulator");
    end
    chk(nbub > 0, 1, "bubbles inserted");
    $display("pointer timing test done");
  endtask

  task automatic t_acc;
    clr;
    send(EPI_ACC_PTR, 1, 2, 0);
    send(EPI_ACC_PTR_MMR, 1, 3, 0);
    send(EPI_ACC_ADD, 1, 2, 0);
    idle(12);
    chk(awq.size(), 3, "accumulator writes");
    chk(awq[0].val[15:0], 16'h0301, "direct pointer read");
    chk(awq[1].val[15:0], 16'h0301, "mapped pointer read");
    chk({awq[2].idx, awq[2].val[15:0]}, {2'd2, 16'h0602}, "accumulator sum");
    $display("accumulator test done");
  endtask

  task automatic t_store;
    clr;
    send(EPI_ST_IMM_INC, 1, 0, 'h1357);
    send(EPI_IO_WR, 0, 2, 'h0044);
    idle(12);
    chk({wrq[0].addr, wrq[0].data}, {23'h40301, 16'h1357}, "store");
    chk({ioq[0].addr[15:0], ioq[0].data}, 32'h0044_0602, "io write");
    $display("store test done");
  endtask

  task automatic t_stack;
    clr;
    send(EPI_SET_CPL, 0, 0, 0);
    send(EPI_PUSH, 0, 2, 0);
    idle(12);
    chk(cpl_q, 1, "compiler mode flag");
    chk({sp_q, ssp_q}, 32'hffff_0000, "push pointers");
    chk({wrq[0].addr, wrq[0].data}, {23'h0ffff, 16'h0602}, "push data");
    stack32 <= 1'b1;
    send(EPI_SP_ADD, 0, 0, 'hfe);
    send(EPI_POP, 0, 1, 0);
    idle(12);
    chk({sp_q, ssp_q}, 32'hfffe_ffff, "32-bit stack");
    chk(rdq[0], 23'h0fffd, "pop address");
    stack32 <= 1'b0;
    send(EPI_RET, 0, 0, 0);
    idle(8);
    chk({sp_q, ssp_q}, 32'hffff_ffff, "return");
    $display("stack test done");
  endtask

  task automatic t_cond;
    clr;
    send(EPI_LD_ACC_INC, 1, 1, 0, EPI_CND_PART);
    send(EPI_LD_ACC_INC, 1, 1, 0, EPI_CND_WHOLE);
    send(EPI_ST_IMM_INC, 1, 0, 'h2222, EPI_CND_PART);
    send(EPI_LD_ACC_INC, 1, 0, 0);
    idle(14);
    chk(rdq[$], 23'h40304, "increments");
    chk(wrq.size(), 0, "suppressed store");
    chk({awq.size(), awq[$].idx}, {32'd1, 2'd0}, "suppressed loads");
    $display("condition test done");
  endtask

  task automatic t_war;
    int b;
    b = nbub;
    clr;
    send(EPI_XPTR_IMM, 2, 0, 'h0abc);
    send(EPI_ACC_PTR, 2, 1, 0);
    send(EPI_XPTR_IMM, 2, 0, 'h0def);
    send(EPI_LD_ACC_INC, 2, 0, 0);
    idle(14);
    chk(awq[0].val[15:0], 16'h0abc, "read before write");
    chk(rdq[0], 23'h00def, "write before read");
    chk(nbub > b, 1, "bubbles inserted");
    $display("ordering test done");
  endtask

  // Second member of a pair reads the pointer before its partner's compute-stage load
  task automatic t_pair;
    clr;
    send(EPI_PTR_IMM, 3, 0, 'h0555);
    send(EPI_LD_ACC_INC, 3, 0, 0, EPI_CND_NONE, 1'b1);
    send(EPI_LD_ACC_INC, 3, 0, 0);
    idle(14);
    chk(rdq.size(), 2, "pair read count");
    chk(rdq[0], 23'h00000, "unprotected pair");
    chk(rdq[1], 23'h00555, "protected follower");
    $display("parallel pair test done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    conclude;
  end

  initial begin
    reset = 1'b1;
    stack32 = 1'b0;
    ins_in = '0;
    mem_rdata = '0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk({issue_ready_q, bubble_q, cpl_q, sp_q, ssp_q}, {1'b1, 34'h0}, "reset values");
    t_ptr;
    t_acc;
    t_store;
    t_stack;
    t_cond;
    t_war;
    t_pair;
    conclude;
  end
endmodule // test_execution_pipeline_interlock

bind epi_interlock epi_asserts chk_i (
  .clk_sys, .reset, .ins_in, .issue_ready_q, .bubble_q, .stack32, .mem_rd_q,
  .mem_wr_q, .io_wr_q, .cpl_q, .sp_q, .ssp_q, .acc_wr_q
);
